// File: design/omd_pkg.sv
// shared constants and types of the overlay map decoder
package omd_pkg;
    // address layout: 2K segments, 24-bit map, top byte picks the window
    localparam int ADDR_W = 32;
    localparam int SEG_BITS = 11;
    localparam int MAP_BITS = 24;
    localparam int IDX_W = MAP_BITS - SEG_BITS;
    localparam int SEG_CNT = 1 << IDX_W;
    localparam int WIN_LSB = 24;
    localparam int WIN_W = ADDR_W - WIN_LSB;
    localparam int SPACE_CNT = 8;
    localparam int WAIT_W = 4;

    typedef enum logic [1:0] {
        TARGET_ATTRIBUTE = 2'h0,
        RW_OVERLAY = 2'h1,
        READ_ONLY_ATTRIBUTE = 2'h2,
        ILLEGAL_ATTRIBUTE = 2'h3
    } omd_attr_e;

    // status space codes; 0, 3 and 4 carry no name
    localparam logic [2:0] USER_DATA_SPACE = 3'h1;
    localparam logic [2:0] USER_PROGRAM_SPACE = 3'h2;
    localparam logic [2:0] SUPERVISOR_DATA_SPACE = 3'h5;
    localparam logic [2:0] SUPERVISOR_PROGRAM_SPACE = 3'h6;
    localparam logic [2:0] CPU_SPACE = 3'h7;

    // reset value of the space enable: both user and supervisor spaces
    localparam logic [SPACE_CNT-1:0] OVE_RESET = 8'h66;
    localparam logic [2:0] SPEED_ZERO = 3'h0;
    localparam logic [2:0] SPEED_FLOOR = 3'h1;

    typedef enum logic [2:0] {
        ST_CLEAR = 3'h0,
        ST_IDLE = 3'h1,
        ST_LOOK = 3'h2,
        ST_WAIT = 3'h3,
        ST_HOLD = 3'h4,
        ST_FILL = 3'h5
    } omd_state_e;
endpackage

// File: design/omd_map_if.sv
// port bundle between the decoder and its attribute store
`timescale 1ns/1ps
interface omd_map_if;
    import omd_pkg::*;
    logic rd_en;
    logic wr_en;
    logic [IDX_W-1:0] addr;
    omd_attr_e wdata;
    omd_attr_e rdata;
    modport ctrl (output rd_en, output wr_en, output addr, output wdata,
                  input rdata);
    modport mem (input rd_en, input wr_en, input addr, input wdata,
                 output rdata);
endinterface

// File: design/omd_attr_mem.sv
// attribute store: one two-bit code per 2K segment, registered read
`timescale 1ns/1ps
module omd_attr_mem (
    // clock
    input wire logic mclk,
    input wire logic clk_en,
    // store port
    omd_map_if.mem port
);
    import omd_pkg::*;

    omd_attr_e store_ff [SEG_CNT];

    // no reset on the array; the decoder sweeps it to target after reset
    always_ff @(posedge mclk) begin
        if (clk_en) begin
            if (port.wr_en) begin
                store_ff[port.addr] <= port.wdata;
            end
            if (port.rd_en) begin
                port.rdata <= store_ff[port.addr];
            end
        end
    end
endmodule

// File: design/omd_decoder.sv
// overlay map decoder: lookup, steering, violations and overlay ack
`timescale 1ns/1ps
// Behaviour
// - every aligned 2K segment carries its own attribute
// - attributes are target, read/write, read-only or illegal
// - unmapped is target; only read/write and read-only use overlay
// - accesses in read/write or read-only segments go to overlay
// - overlay steering further gated by the space enable
// - overlay answers only if mapped and the status space enabled
// - default setting adds no wait states only in the slow 32-bit variant; at zero it follows the clock minimum and waits for the target ack
// - running write to read-only: no change, abort, write violation
// - running access to illegal segment aborts, access violation
// - target segments are neither answered nor checked
// - mapping marks the smallest enclosing set of 2K segments
// - after reset: all target, four spaces enabled, speed default
// - map indexed by 24 address bits, sixteen megabytes
// - 32-bit variant: one window byte; a non-target mapping outside it is an error
// - effective speed is the setting, or the minimum when zero
// - speed zero waits for target ack and overlay ack both
// - speeds 1 to 7 ignore the target ack
// - bad speed rejected; low speed raised to the minimum
// - fast or 24-bit variant defaults to zero; slow 32-bit variant refuses zero
// - at the slowest clock overlay adds no wait states
// - wait states follow clock rate, writes may take one more
module omd_decoder #(
    parameter bit ADDR32 = 1'b0,
    parameter bit FAST_VARIANT = 1'b1,
    parameter int OVL_AW = 19
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    // processor bus pins
    input wire logic cpu_as_b,
    input wire logic cpu_read,
    input wire logic [2:0] cpu_space,
    input wire logic [omd_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic target_ack_b,
    // emulator state and clock-rate limits
    input wire logic run_mode,
    input wire logic [2:0] speed_min,
    input wire logic write_extra_wait,
    // map programming
    input wire logic map_wr,
    input wire logic clear_map_command,
    input wire logic [omd_pkg::ADDR_W-1:0] map_lo,
    input wire logic [omd_pkg::ADDR_W-1:0] map_hi,
    input wire omd_pkg::omd_attr_e map_attr,
    // space enable, speed and flag clear
    input wire logic ove_wr,
    input wire logic [omd_pkg::SPACE_CNT-1:0] ove_val,
    input wire logic ovs_wr,
    input wire logic [2:0] ovs_val,
    input wire logic viol_clr,
    // overlay memory and processor answer
    output logic overlay_sel_ff,
    output logic overlay_we_ff,
    output logic [OVL_AW-1:0] overlay_addr_ff,
    output logic transfer_ack_b_ff,
    // status
    output logic write_violation_ff,
    output logic access_violation_ff,
    output logic run_abort_ff,
    output logic map_busy_ff,
    output logic map_error_ff,
    output logic speed_error_ff,
    output logic [omd_pkg::SPACE_CNT-1:0] overlay_space_enable_ff,
    output logic [2:0] overlay_speed_setting_ff,
    output logic [2:0] effective_hardware_speed_ff
);
    import omd_pkg::*;

    localparam int SYNC_W = ADDR_W + 6;
    localparam bit ZERO_OK = FAST_VARIANT || !ADDR32;
    localparam logic [2:0] OVS_RESET = ZERO_OK ? SPEED_ZERO : SPEED_FLOOR;
    localparam logic [IDX_W-1:0] IDX_LAST = '1;

    omd_map_if mif ();

    omd_attr_mem u_store (
        .mclk(mclk),
        .clk_en(clk_en),
        .port(mif.mem)
    );

    // pins come from the target clock domain: two flops before use
    logic [SYNC_W-1:0] pin_s1_ff;
    logic [SYNC_W-1:0] pin_s2_ff;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_s1_ff <= '1;
            pin_s2_ff <= '1;
        end else if (clk_en) begin
            pin_s1_ff <= {cpu_as_b, target_ack_b, cpu_read, cpu_space,
                          cpu_addr};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    logic as_s;
    logic tack_s;
    logic read_s;
    logic [2:0] space_s;
    logic [ADDR_W-1:0] addr_s;
    assign as_s = pin_s2_ff[SYNC_W-1];
    assign tack_s = pin_s2_ff[SYNC_W-2];
    assign read_s = pin_s2_ff[SYNC_W-3];
    assign space_s = pin_s2_ff[ADDR_W+2:ADDR_W];
    assign addr_s = pin_s2_ff[ADDR_W-1:0];

    omd_state_e state_ff;
    logic [ADDR_W-1:0] cyc_addr_ff;
    logic cyc_read_ff;
    logic [2:0] cyc_space_ff;
    logic [IDX_W-1:0] fill_ff;
    logic [IDX_W-1:0] fill_end_ff;
    omd_attr_e fill_attr_ff;
    logic [WIN_W-1:0] win_ff;
    logic win_valid_ff;
    logic [WAIT_W-1:0] wait_ff;
    logic tgt_seen_ff;

    // map command checks; the 24-bit variant has a single window
    logic [WIN_W-1:0] lo_top;
    logic [WIN_W-1:0] hi_top;
    logic [WIN_W-1:0] cmp_win;
    logic [IDX_W-1:0] start_idx;
    logic [IDX_W-1:0] end_idx;
    logic map_bad;
    logic map_skip;
    logic map_go;
    logic clear_go;
    assign lo_top = ADDR32 ? map_lo[ADDR_W-1:WIN_LSB] : '0;
    assign hi_top = ADDR32 ? map_hi[ADDR_W-1:WIN_LSB] : '0;
    assign cmp_win = win_valid_ff ? win_ff : lo_top;
    assign start_idx = (lo_top < cmp_win) ? '0 : map_lo[MAP_BITS-1:SEG_BITS];
    assign end_idx = (hi_top > cmp_win) ? IDX_LAST
                                        : map_hi[MAP_BITS-1:SEG_BITS];
    assign map_bad = run_mode || (map_lo > map_hi)
        || (map_attr != TARGET_ATTRIBUTE
            && (lo_top != hi_top || lo_top != cmp_win));
    // target ranges outside the window touch nothing stored
    assign map_skip = (cmp_win < lo_top) || (cmp_win > hi_top);
    assign map_go = map_wr && !map_bad && !map_skip;
    assign clear_go = clear_map_command && !run_mode;

    // lookup result, valid in the look state
    logic win_ok;
    omd_attr_e eff_attr;
    logic space_en;
    logic hit_illegal;
    logic hit_ro_wr;
    logic hit_ovl;
    logic [WAIT_W-1:0] wait_load;
    logic ack_ok;
    // accesses outside the window are plain target
    assign win_ok = !ADDR32 || cyc_addr_ff[ADDR_W-1:WIN_LSB] == win_ff;
    assign eff_attr = win_ok ? mif.rdata : TARGET_ATTRIBUTE;
    assign space_en = overlay_space_enable_ff[cyc_space_ff];
    assign hit_illegal = run_mode && eff_attr == ILLEGAL_ATTRIBUTE;
    // host writes in pause still land in read-only overlay
    assign hit_ro_wr = run_mode && !cyc_read_ff
        && eff_attr == READ_ONLY_ATTRIBUTE;
    assign hit_ovl = space_en && !hit_ro_wr
        && (eff_attr == RW_OVERLAY || eff_attr == READ_ONLY_ATTRIBUTE);
    // speed 1 is no delay; writes may need one more cycle
    assign wait_load = WAIT_W'(effective_hardware_speed_ff) - 4'h1
        + WAIT_W'(!cyc_read_ff && write_extra_wait);
    // speed zero also needs the target ack
    assign ack_ok = overlay_speed_setting_ff != SPEED_ZERO
        || tgt_seen_ff || !tack_s;

    // early registered lookup, writes during sweeps
    always_comb begin
        mif.rd_en = 1'b0;
        mif.wr_en = 1'b0;
        mif.addr = addr_s[MAP_BITS-1:SEG_BITS];
        mif.wdata = fill_attr_ff;
        if (state_ff == ST_CLEAR || state_ff == ST_FILL) begin
            mif.wr_en = 1'b1;
            mif.addr = fill_ff;
        end else if (state_ff == ST_IDLE && !as_s && !map_go
                     && !clear_go) begin
            mif.rd_en = 1'b1;
        end
    end

    // sequencing of map sweeps and bus cycles
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            // sweep the whole map to target after reset
            state_ff <= ST_CLEAR;
            fill_ff <= '0;
            fill_end_ff <= IDX_LAST;
            fill_attr_ff <= TARGET_ATTRIBUTE;
            map_busy_ff <= 1'b1;
            cyc_addr_ff <= '0;
            cyc_read_ff <= 1'b1;
            cyc_space_ff <= '0;
            wait_ff <= '0;
        end else if (clk_en) begin
            case (state_ff)
                ST_CLEAR, ST_FILL: begin
                    fill_ff <= fill_ff + 1'b1;
                    if (fill_ff == fill_end_ff) begin
                        state_ff <= ST_IDLE;
                        map_busy_ff <= 1'b0;
                    end
                end
                ST_IDLE: begin
                    // map commands win; a waiting bus cycle is served after
                    // clear to target
                    if (clear_go) begin
                        state_ff <= ST_CLEAR;
                        fill_ff <= '0;
                        fill_end_ff <= IDX_LAST;
                        fill_attr_ff <= TARGET_ATTRIBUTE;
                        map_busy_ff <= 1'b1;
                    end else if (map_go) begin
                        state_ff <= ST_FILL;
                        fill_ff <= start_idx;
                        fill_end_ff <= end_idx;
                        fill_attr_ff <= map_attr;
                        map_busy_ff <= 1'b1;
                    end else if (!as_s) begin
                        state_ff <= ST_LOOK;
                        cyc_addr_ff <= addr_s;
                        cyc_read_ff <= read_s;
                        cyc_space_ff <= space_s;
                    end
                end
                ST_LOOK: begin
                    // target and violations go straight to hold
                    if (hit_ovl) begin
                        state_ff <= ST_WAIT;
                        wait_ff <= wait_load;
                    end else begin
                        state_ff <= ST_HOLD;
                    end
                end
                ST_WAIT: begin
                    if (wait_ff != '0) begin
                        wait_ff <= wait_ff - 1'b1;
                    end else if (ack_ok) begin
                        state_ff <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (as_s) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // target ack remembered during the cycle, forgotten between cycles
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tgt_seen_ff <= 1'b0;
        end else if (clk_en) begin
            if (state_ff == ST_IDLE) begin
                tgt_seen_ff <= 1'b0;
            end else if (!tack_s) begin
                tgt_seen_ff <= 1'b1;
            end
        end
    end

    // overlay strobes and processor acknowledge
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            overlay_sel_ff <= 1'b0;
            overlay_we_ff <= 1'b0;
            overlay_addr_ff <= '0;
            transfer_ack_b_ff <= 1'b1;
        end else if (clk_en) begin
            if (state_ff == ST_LOOK && hit_ovl) begin
                overlay_sel_ff <= 1'b1;
                overlay_we_ff <= !cyc_read_ff;
                overlay_addr_ff <= cyc_addr_ff[OVL_AW-1:0];
            end else if (state_ff == ST_WAIT && wait_ff == '0 && ack_ok) begin
                // own ack at every speed; at zero only once the target ack is seen
                transfer_ack_b_ff <= 1'b0;
            end else if (state_ff == ST_HOLD && as_s) begin
                overlay_sel_ff <= 1'b0;
                overlay_we_ff <= 1'b0;
                transfer_ack_b_ff <= 1'b1;
            end
        end
    end

    // sticky violation flags; a new violation beats a clear
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            write_violation_ff <= 1'b0;
            access_violation_ff <= 1'b0;
            run_abort_ff <= 1'b0;
        end else if (clk_en) begin
            run_abort_ff <= 1'b0;
            if (viol_clr) begin
                write_violation_ff <= 1'b0;
                access_violation_ff <= 1'b0;
            end
            if (state_ff == ST_LOOK && hit_illegal) begin
                access_violation_ff <= 1'b1;
                run_abort_ff <= 1'b1;
            end
            if (state_ff == ST_LOOK && hit_ro_wr) begin
                write_violation_ff <= 1'b1;
                run_abort_ff <= 1'b1;
            end
        end
    end

    // window tracking and command error
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            win_ff <= '0;
            win_valid_ff <= 1'b0;
            map_error_ff <= 1'b0;
        end else if (clk_en && state_ff == ST_IDLE) begin
            if (clear_map_command) begin
                // only a clear frees the window
                map_error_ff <= run_mode;
                if (!run_mode) begin
                    win_valid_ff <= 1'b0;
                end
            end else if (map_wr) begin
                // reject a mapping outside the window
                map_error_ff <= map_bad;
                if (map_go && map_attr != TARGET_ATTRIBUTE) begin
                    win_ff <= lo_top;
                    win_valid_ff <= 1'b1;
                end
            end
        end
    end

    // space enable and speed settings
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            // default speed depends on the variant
            overlay_space_enable_ff <= OVE_RESET;
            overlay_speed_setting_ff <= OVS_RESET;
            speed_error_ff <= 1'b0;
            effective_hardware_speed_ff <= SPEED_FLOOR;
        end else if (clk_en) begin
            if (ove_wr) begin
                overlay_space_enable_ff <= ove_val;
            end
            if (ovs_wr) begin
                // refuse zero where absent, raise to minimum
                if (!ZERO_OK && ovs_val == SPEED_ZERO) begin
                    speed_error_ff <= 1'b1;
                end else begin
                    speed_error_ff <= 1'b0;
                    overlay_speed_setting_ff <= ovs_val;
                    if (ovs_val != SPEED_ZERO && ovs_val < speed_min) begin
                        overlay_speed_setting_ff <= speed_min;
                    end
                end
            end
            // zero means the minimum for the clock
            // minimum 1 at the slowest clock gives no wait
            if (overlay_speed_setting_ff != SPEED_ZERO) begin
                effective_hardware_speed_ff <= overlay_speed_setting_ff;
            end else if (speed_min > SPEED_FLOOR) begin
                effective_hardware_speed_ff <= speed_min;
            end else begin
                effective_hardware_speed_ff <= SPEED_FLOOR;
            end
        end
    end

    // checks assume clk_en stays high
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_reset_defaults: assert property (
        !$past(rst_b) |-> map_busy_ff && state_ff == ST_CLEAR
            && overlay_space_enable_ff == OVE_RESET
            && overlay_speed_setting_ff == OVS_RESET)
        else $error("reset defaults wrong");
    a_overlay_steer: assert property (
        clk_en && state_ff == ST_LOOK && hit_ovl
            |=> overlay_sel_ff && state_ff == ST_WAIT)
        else $error("mapped access not steered to overlay");
    a_space_gate: assert property (
        clk_en && state_ff == ST_LOOK && !space_en
            |=> !overlay_sel_ff)
        else $error("disabled space reached overlay");
    a_ro_write_blocked: assert property (
        clk_en && state_ff == ST_LOOK && hit_ro_wr
            |=> !overlay_we_ff && write_violation_ff && run_abort_ff
            ##1 !run_abort_ff)
        else $error("read-only write not blocked");
    a_illegal_abort: assert property (
        clk_en && state_ff == ST_LOOK && hit_illegal
            |=> access_violation_ff && run_abort_ff && !overlay_sel_ff)
        else $error("illegal access not flagged");
    a_target_quiet: assert property (
        clk_en && state_ff == ST_LOOK && eff_attr == TARGET_ATTRIBUTE
            |=> !overlay_sel_ff && transfer_ack_b_ff && !run_abort_ff)
        else $error("target access touched by overlay");
    a_fill_range: assert property (
        clk_en && state_ff == ST_IDLE && map_go && !clear_go
            |=> state_ff == ST_FILL
            && fill_ff == $past(map_lo[MAP_BITS-1:SEG_BITS]))
        else $error("fill does not start at enclosing segment");
    a_window_reject: assert property (
        clk_en && state_ff == ST_IDLE && map_wr && !clear_map_command
            && map_bad |=> map_error_ff && state_ff != ST_FILL)
        else $error("bad mapping accepted");
    a_speed_effective: assert property (
        clk_en && overlay_speed_setting_ff != SPEED_ZERO
            |=> effective_hardware_speed_ff == $past(overlay_speed_setting_ff))
        else $error("effective speed differs from setting");
    a_combined_ack: assert property (
        $fell(transfer_ack_b_ff) && overlay_speed_setting_ff == SPEED_ZERO
            |-> $past(tgt_seen_ff) || !$past(tack_s))
        else $error("ack given without target ack");
    a_no_wait_ack: assert property (
        clk_en && state_ff == ST_WAIT && wait_ff == '0
            && overlay_speed_setting_ff != SPEED_ZERO
            |=> !transfer_ack_b_ff)
        else $error("overlay ack late");
    a_speed_floor: assert property (
        clk_en && ovs_wr && ovs_val != SPEED_ZERO && ovs_val < speed_min
            |=> overlay_speed_setting_ff == $past(speed_min))
        else $error("speed not raised to minimum");

    c_overlay_read: cover property (
        state_ff == ST_WAIT && cyc_read_ff ##[1:20] !transfer_ack_b_ff);
    c_write_violation: cover property ($rose(write_violation_ff));
    c_access_violation: cover property ($rose(access_violation_ff));
    c_map_fill_done: cover property (
        state_ff == ST_FILL ##[1:1000] state_ff == ST_IDLE);
endmodule

// File: verification/omd_target_model.sv
// target memory model: answers a bus cycle after a set delay
`timescale 1ns/1ps
module omd_target_model (
    // clock
    input wire logic mclk,
    // processor bus
    input wire logic cpu_as_b,
    input wire logic [4:0] delay,
    output logic target_ack_b
);
    logic [4:0] cnt_ff;
    always_ff @(posedge mclk) begin
        cnt_ff <= cpu_as_b ? 5'h0 : cnt_ff + {4'h0, cnt_ff != 5'h1f};
    end
    // slow target ack
    // released ack goes high by pull-up; delay zero never answers
    assign target_ack_b = cpu_as_b | (delay == 5'h0) | (cnt_ff < delay);
endmodule

// File: verification/tb.sv
// self-checking bench of the overlay map decoder
`timescale 1ns/1ps
module tb;
    import omd_pkg::*;
    logic mclk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, cpu_as_b = 1'b1;
    logic cpu_read = 1'b1, run_mode = 1'b0, write_extra_wait = 1'b0;
    logic map_wr = 1'b0, clear_map_command = 1'b0, ove_wr = 1'b0;
    logic ovs_wr = 1'b0, viol_clr = 1'b0, target_ack_b;
    logic [2:0] cpu_space = 3'h1, speed_min = 3'h1, ovs_val = 3'h1;
    logic [31:0] cpu_addr = 32'h0, map_lo = 32'h0, map_hi = 32'h0;
    logic [7:0] ove_val = 8'h66;
    logic [4:0] delay = 5'h0;
    omd_attr_e map_attr = TARGET_ATTRIBUTE;
    logic overlay_sel_ff, overlay_we_ff, transfer_ack_b_ff, run_abort_ff;
    logic write_violation_ff, access_violation_ff, map_busy_ff;
    logic map_error_ff, speed_error_ff;
    logic [18:0] overlay_addr_ff;
    logic [7:0] overlay_space_enable_ff;
    logic [2:0] overlay_speed_setting_ff, effective_hardware_speed_ff;
    logic [31:0] adr [4] = '{32'h0fff, 32'h1000, 32'h17ff, 32'h1800};
    int errors = 0, compares = 0, seed = 32'hcf4f, lat1, lat;
    logic s, w, ab;
    logic [31:0] ra;
    omd_decoder u_dut (.mclk, .rst_b, .clk_en, .cpu_as_b, .cpu_read,
        .cpu_space, .cpu_addr, .target_ack_b, .run_mode, .speed_min,
        .write_extra_wait, .map_wr, .clear_map_command, .map_lo, .map_hi,
        .map_attr, .ove_wr, .ove_val, .ovs_wr, .ovs_val, .viol_clr,
        .overlay_sel_ff, .overlay_we_ff, .overlay_addr_ff,
        .transfer_ack_b_ff, .write_violation_ff, .access_violation_ff,
        .run_abort_ff, .map_busy_ff, .map_error_ff, .speed_error_ff,
        .overlay_space_enable_ff, .overlay_speed_setting_ff,
        .effective_hardware_speed_ff);
    omd_target_model u_tgt (.mclk, .cpu_as_b, .delay, .target_ack_b);
    always #5 mclk = ~mclk;
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] v);
        compares++;
        if (v !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic idle;
        int i;
        i = 0;
        repeat (2) @(posedge mclk);
        while (map_busy_ff !== 1'b0 && i < 9000) begin
            @(posedge mclk);
            #1;
            i++;
        end
        chk("map_busy", 0, map_busy_ff);
    endtask
    task automatic map(input logic [31:0] lo, hi, input omd_attr_e a);
        @(posedge mclk);
        map_lo <= lo;
        map_hi <= hi;
        map_attr <= a;
        map_wr <= 1'b1;
        @(posedge mclk);
        map_wr <= 1'b0;
        idle();
    endtask
    task automatic spd(input logic [2:0] v);
        @(posedge mclk);
        ovs_val <= v;
        ovs_wr <= 1'b1;
        @(posedge mclk);
        ovs_wr <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    // one bus cycle: latency to ack (40 = none), overlay select, write, abort
    task automatic bus(input logic [31:0] a, input logic r,
        input logic [2:0] sp);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_read <= r;
        cpu_space <= sp;
        cpu_as_b <= 1'b0;
        lat = 0;
        {s, w, ab} = 3'h0;
        while (transfer_ack_b_ff !== 1'b0 && lat < 40) begin
            @(posedge mclk);
            #1;
            lat++;
            s = s | (overlay_sel_ff === 1'b1);
            w = w | (overlay_we_ff === 1'b1);
            ab = ab | (run_abort_ff === 1'b1);
        end
        @(posedge mclk);
        cpu_as_b <= 1'b1;
        repeat (6) @(posedge mclk);
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        #1;
        chk("space_en", 32'h66, overlay_space_enable_ff);
        chk("speed", 0, overlay_speed_setting_ff);
        chk("eff_speed", 1, effective_hardware_speed_ff);
        idle();
        spd(3'h1);
        map(32'h1234, 32'h1234, RW_OVERLAY);
        for (int i = 0; i < 4; i++) begin
            bus(adr[i], 1'b1, USER_DATA_SPACE);
            chk("sel", (i == 1 || i == 2), s);
            if (i == 1) lat1 = lat;
        end
        spd(3'h3);
        bus(32'h1000, 1'b1, SUPERVISOR_DATA_SPACE);
        chk("lat_s3", lat1 + 2, lat);
        write_extra_wait <= 1'b1;
        bus(32'h1004, 1'b0, SUPERVISOR_PROGRAM_SPACE);
        chk("lat_wr", lat1 + 3, lat);
        chk("we", 1, w);
        chk("ovl_addr", 32'h1004, overlay_addr_ff);
        speed_min <= 3'h2;
        delay <= 5'd25;
        spd(3'h0);
        chk("spd_err", 0, speed_error_ff);
        chk("eff_min", 2, effective_hardware_speed_ff);
        bus(32'h1008, 1'b1, USER_PROGRAM_SPACE);
        chk("tgt_wait", 1, lat >= 25 && lat < 40);
        spd(3'h1);
        chk("spd_floor", 2, overlay_speed_setting_ff);
        @(posedge mclk);
        // bit n enables space n: user program only
        ove_val <= 8'h04;
        ove_wr <= 1'b1;
        @(posedge mclk);
        ove_wr <= 1'b0;
        bus(32'h1000, 1'b1, USER_PROGRAM_SPACE);
        chk("sel_on", 1, s);
        bus(32'h1000, 1'b1, USER_DATA_SPACE);
        chk("sel_off", 0, s);
        ove_val <= 8'h66;
        ove_wr <= 1'b1;
        map(32'h2000, 32'h27ff, READ_ONLY_ATTRIBUTE);
        map(32'h3000, 32'h3000, ILLEGAL_ATTRIBUTE);
        ove_wr <= 1'b0;
        run_mode <= 1'b1;
        bus(32'h2010, 1'b0, USER_DATA_SPACE);
        chk("ro_we", 0, w);
        chk("ro_flag", 2'h3, {write_violation_ff, ab});
        chk("ro_av", 0, access_violation_ff);
        // one-cycle clear, so the next violation is not wiped
        viol_clr <= 1'b1;
        @(posedge mclk);
        viol_clr <= 1'b0;
        bus(32'h3100, 1'b1, USER_DATA_SPACE);
        chk("ilg_flag", 3'h7, {lat == 40, access_violation_ff, ab});
        chk("wv_clr", 0, write_violation_ff);
        // mapping while running is refused, so 5000 stays target
        map(32'h5000, 32'h5000, RW_OVERLAY);
        chk("map_err", 1, map_error_ff);
        bus(32'h5000, 1'b0, USER_DATA_SPACE);
        chk("tgt_sel", 0, s | ab);
        run_mode <= 1'b0;
        repeat (20) begin
            ra = $random(seed);
            bus(ra & 32'h3fff, ra[31], ra[30] ? 3'h1 : 3'h6);
            chk("rnd_sel", ra[13:11] inside {3'h2, 3'h4}, s);
        end
        // clear before any mapping in another window
        @(posedge mclk);
        clear_map_command <= 1'b1;
        @(posedge mclk);
        clear_map_command <= 1'b0;
        idle();
        bus(32'h1000, 1'b1, USER_DATA_SPACE);
        chk("cleared", 0, s);
        tally_and_finish();
    end
endmodule
